//--- hdl/sync_rx_pkg.sv
// constants shared by the synchronous master receive path
package sync_rx_pkg;

  // ------------------------------------------------------------
  // data and divisor widths
  // ------------------------------------------------------------
  localparam int WORD_W = 9;
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;
  localparam int DIV_LOW_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam int NINTH_POS = 8;

  // ------------------------------------------------------------
  // word lengths and buffer shape
  // ------------------------------------------------------------
  localparam logic [BIT_CNT_W-1:0] BITS_SHORT = 4'h8;
  localparam logic [BIT_CNT_W-1:0] BITS_LONG = 4'h9;
  localparam int BUF_DEPTH = 2;

  // ------------------------------------------------------------
  // reset values and divisor high byte fill
  // ------------------------------------------------------------
  localparam logic SHIFT_CLK_IDLE = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RESET = 9'h000;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
  localparam logic [DIV_LOW_W-1:0] DIV_HIGH_ZERO = 8'h00;

  // ------------------------------------------------------------
  // link side sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_HIGH,
    LINK_LOW
  } link_state_t;

endpackage

//--- hdl/rx_word_buffer.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module rx_word_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic out_valid_reg;

  wire push = in_valid && in_ready;
  wire head_load = (!out_valid_reg || out_ready) && (count_reg != '0);
  wire [PTR_W-1:0] wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
  wire [PTR_W-1:0] rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;

  assign in_ready = (count_reg != COUNT_FULL);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  // ------------------------------------------------------------
  // storage, one generate entry per slot
  // ------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_reg[i] <= '0;
      end else if (push && (wr_ptr_reg == PTR_W'(i))) begin
        mem_reg[i] <= in_data;
      end
    end
  end

  // ------------------------------------------------------------
  // pointers and registered head
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_data_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_next;
      end
      if (head_load) begin
        rd_ptr_reg <= rd_ptr_next;
        out_data_reg <= mem_reg[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
      count_reg <= count_reg + (PTR_W + 1)'(push) - (PTR_W + 1)'(head_load);
    end
  end

endmodule // rx_word_buffer

`default_nettype wire

//--- hdl/sync_master_serial_receiver.sv
// synchronous master receive path: shift clock generation, sampling, hand-off
// Operation
// [R1] reception starts only when single or continuous receive enable is set
// [R2] data input sampled on each falling edge of the generated shift clock
// [R3] single receive enable takes exactly one word then stops
// [R4] continuous enable keeps receiving words until software clears it
// [R5] both enables set behaves as continuous reception
// [R6] software loads divisor pair and wide divisor select before receiving
// [R7] software sets clocked mode, port enable and master clock source
// [R8] software clears both receive enables before changing word options
// [R9] ninth-bit enable makes each word nine bits long
// [R10] completed word sets receive complete flag; interrupt when enabled
// [R11] ninth bit and error indication presented for the current word
// [R12] low eight received bits presented as receive data
// [R13] clearing continuous enable clears any pending reception error
// [R14] software sets global and peripheral interrupt enables for interrupts
// [R15] shift clock runs at divisor rate, one clock per received bit
`timescale 1ns/100ps
`default_nettype none

module sync_master_serial_receiver
  import sync_rx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic serial_port_enable,
  input wire logic sync_mode_select,
  input wire logic clock_source_master_select,
  input wire logic single_receive_enable,
  input wire logic continuous_receive_enable,
  input wire logic ninth_bit_receive_enable,
  input wire logic wide_divisor_select,
  input wire logic [sync_rx_pkg::DIV_W-1:0] baud_divisor_pair,
  input wire logic receive_interrupt_enable,
  input wire logic data_read,
  input wire logic serial_data_input,
  output logic shift_clk_out,
  output logic shift_clk_oe_n,
  output logic [sync_rx_pkg::DATA_W-1:0] receive_data_reg,
  output logic rx_ninth_bit,
  output logic reception_error,
  output logic receive_complete_flag,
  output logic receive_irq
);

  // ------------------------------------------------------------
  // link domain: synchronisers
  // ------------------------------------------------------------
  logic [1:0] continuous_receive_enable_sync_reg;
  logic [1:0] single_receive_enable_sync_reg;
  logic [1:0] master_sync_reg;
  logic [1:0] data_sync_reg;
  logic [1:0] ack_sync_reg;
  logic [1:0] nine_sync_reg;
  logic [1:0] wide_sync_reg;
  logic [DIV_W-1:0] div_meta_reg;
  logic [DIV_W-1:0] div_sync_reg;
  logic ack_tog_reg;

  // word options cross as plain levels: they only move while receive is off
  wire master_in = serial_port_enable && sync_mode_select && clock_source_master_select;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      continuous_receive_enable_sync_reg <= '0;
      single_receive_enable_sync_reg <= '0;
      master_sync_reg <= '0;
      data_sync_reg <= '0;
      ack_sync_reg <= '0;
      nine_sync_reg <= '0;
      wide_sync_reg <= '0;
      div_meta_reg <= DIV_RESET;
      div_sync_reg <= DIV_RESET;
    end else begin
      continuous_receive_enable_sync_reg <= {continuous_receive_enable_sync_reg[0], continuous_receive_enable};
      single_receive_enable_sync_reg <= {single_receive_enable_sync_reg[0], single_receive_enable};
      master_sync_reg <= {master_sync_reg[0], master_in};
      data_sync_reg <= {data_sync_reg[0], serial_data_input};
      ack_sync_reg <= {ack_sync_reg[0], ack_tog_reg};
      nine_sync_reg <= {nine_sync_reg[0], ninth_bit_receive_enable};
      wide_sync_reg <= {wide_sync_reg[0], wide_divisor_select};
      div_meta_reg <= baud_divisor_pair;
      div_sync_reg <= div_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // link domain: shift clock and sampling
  // ------------------------------------------------------------
  link_state_t link_state_reg;
  link_state_t link_state_next;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [BIT_CNT_W-1:0] word_len_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] link_word_reg;
  logic req_tog_reg;
  logic abort_tog_reg;
  logic single_done_reg;
  logic shift_clk_reg;
  logic clk_oe_n_reg;
  // divisor and length are only taken while idle, so a word never changes rate mid-way
  logic [DIV_W-1:0] div_hold_reg;
  logic wide_div_reg;

  wire continuous_receive_enable_l = continuous_receive_enable_sync_reg[1];
  wire single_receive_enable_l = single_receive_enable_sync_reg[1];
  wire master_l = master_sync_reg[1];
  // continuous mode wins when both are set
  wire single_mode = single_receive_enable_l && !continuous_receive_enable_l; // [R5]
  wire rx_enabled = master_l && (continuous_receive_enable_l || (single_receive_enable_l && !single_done_reg)); // [R1] [R3] [R4] [R5]
  // a word still waiting on the other side stalls the next one
  wire handoff_busy = (req_tog_reg != ack_sync_reg[1]);
  wire [DIV_W-1:0] div_limit = wide_div_reg ? div_hold_reg : {DIV_HIGH_ZERO, div_hold_reg[DIV_LOW_W-1:0]};
  wire half_done = (div_cnt_reg == div_limit); // [R15]
  wire last_bit = (bit_cnt_reg == word_len_reg - 4'h1);
  wire start_word = (link_state_reg == LINK_IDLE) && rx_enabled && !handoff_busy; // [R1]
  wire abort_word = (link_state_reg != LINK_IDLE) && !rx_enabled;
  wire fall_edge = (link_state_reg == LINK_HIGH) && half_done && !abort_word;
  wire word_done = fall_edge && last_bit;

  always_comb begin
    link_state_next = link_state_reg;
    unique case (link_state_reg)
      LINK_IDLE: begin
        if (start_word) begin
          link_state_next = LINK_LOW;
        end
      end
      LINK_LOW: begin
        if (abort_word) begin
          link_state_next = LINK_IDLE;
        end else if (half_done) begin
          link_state_next = LINK_HIGH;
        end
      end
      LINK_HIGH: begin
        if (abort_word || word_done) begin
          link_state_next = LINK_IDLE;
        end else if (half_done) begin
          link_state_next = LINK_LOW;
        end
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_state_reg <= LINK_IDLE;
      div_cnt_reg <= DIV_RESET;
      div_hold_reg <= DIV_RESET;
      wide_div_reg <= 1'b0;
      word_len_reg <= BITS_SHORT;
    end else begin
      link_state_reg <= link_state_next;
      if (link_state_reg == LINK_IDLE || half_done) begin
        div_cnt_reg <= DIV_RESET; // [R15]
      end else begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
      if (link_state_reg == LINK_IDLE) begin
        div_hold_reg <= div_sync_reg;
        wide_div_reg <= wide_sync_reg[1];
        word_len_reg <= nine_sync_reg[1] ? BITS_LONG : BITS_SHORT; // [R9]
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= '0;
      shift_reg <= WORD_RESET;
      link_word_reg <= WORD_RESET;
      req_tog_reg <= 1'b0;
      abort_tog_reg <= 1'b0;
      single_done_reg <= 1'b0;
    end else begin
      if (start_word) begin
        bit_cnt_reg <= '0;
        shift_reg <= WORD_RESET;
      end else if (fall_edge) begin
        shift_reg[bit_cnt_reg] <= data_sync_reg[1]; // [R2]
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (word_done) begin
        link_word_reg <= shift_reg;
        link_word_reg[bit_cnt_reg] <= data_sync_reg[1]; // [R2]
        req_tog_reg <= ~req_tog_reg;
      end
      if (abort_word) begin
        abort_tog_reg <= ~abort_tog_reg;
      end
      if (!single_receive_enable_l) begin
        single_done_reg <= 1'b0;
      end else if (word_done && single_mode) begin
        single_done_reg <= 1'b1; // [R3]
      end
    end
  end

  // ------------------------------------------------------------
  // link domain: pin drivers
  // ------------------------------------------------------------
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_clk_reg <= SHIFT_CLK_IDLE;
      clk_oe_n_reg <= 1'b1;
    end else begin
      shift_clk_reg <= (link_state_next == LINK_HIGH); // [R15]
      clk_oe_n_reg <= !master_l;
    end
  end

  assign shift_clk_out = shift_clk_reg;
  assign shift_clk_oe_n = clk_oe_n_reg;

  // ------------------------------------------------------------
  // reference domain: word hand-off and error event
  // ------------------------------------------------------------
  logic [1:0] req_sync_reg;
  logic [1:0] abort_sync_reg;
  logic abort_seen_reg;
  logic continuous_receive_enable_prev_reg;
  logic error_reg;
  logic flag_reg;
  logic irq_reg;
  logic [WORD_W-1:0] present_reg;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [WORD_W-1:0] buf_out_data;

  // link word is stable while the request toggle differs from the acknowledge
  wire word_pending = (req_sync_reg[1] != ack_tog_reg);
  wire word_push = word_pending && buf_in_ready;
  wire abort_event = (abort_sync_reg[1] != abort_seen_reg);
  wire continuous_receive_enable_cleared = continuous_receive_enable_prev_reg && !continuous_receive_enable;
  wire present_ready = !flag_reg || data_read;
  wire present_load = buf_out_valid && present_ready;
  wire flag_next = present_load || (flag_reg && !data_read);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync_reg <= '0;
      abort_sync_reg <= '0;
      abort_seen_reg <= 1'b0;
      ack_tog_reg <= 1'b0;
      continuous_receive_enable_prev_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[0], req_tog_reg};
      abort_sync_reg <= {abort_sync_reg[0], abort_tog_reg};
      abort_seen_reg <= abort_sync_reg[1];
      continuous_receive_enable_prev_reg <= continuous_receive_enable;
      if (word_push) begin
        ack_tog_reg <= req_sync_reg[1];
      end
    end
  end

  rx_word_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(word_pending),
    .in_ready(buf_in_ready),
    .in_data(link_word_reg),
    .out_valid(buf_out_valid),
    .out_ready(present_ready),
    .out_data(buf_out_data)
  );

  // ------------------------------------------------------------
  // reference domain: presented word, flag, error, interrupt
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      present_reg <= WORD_RESET;
      flag_reg <= 1'b0;
      irq_reg <= 1'b0;
      error_reg <= 1'b0;
    end else begin
      if (present_load) begin
        present_reg <= buf_out_data; // [R11] [R12]
      end
      flag_reg <= flag_next; // [R10]
      irq_reg <= flag_next && receive_interrupt_enable; // [R10]
      // a new abort in the clearing cycle still leaves the error set
      if (abort_event) begin
        error_reg <= 1'b1; // [R11]
      end else if (continuous_receive_enable_cleared) begin
        error_reg <= 1'b0; // [R13]
      end
    end
  end

  assign receive_data_reg = present_reg[DATA_W-1:0]; // [R12]
  assign rx_ninth_bit = present_reg[NINTH_POS]; // [R9] [R11]
  assign reception_error = error_reg;
  assign receive_complete_flag = flag_reg;
  assign receive_irq = irq_reg;

endmodule // sync_master_serial_receiver

`default_nettype wire

//--- testbench/sync_rx_monitor.sv
// checker that watches the receive path ports
`timescale 1ns/100ps
`default_nettype none

module sync_rx_monitor
  import sync_rx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic single_receive_enable,
  input wire logic continuous_receive_enable,
  input wire logic wide_divisor_select,
  input wire logic [sync_rx_pkg::DIV_W-1:0] baud_divisor_pair,
  input wire logic receive_interrupt_enable,
  input wire logic data_read,
  input wire logic shift_clk_out,
  input wire logic shift_clk_oe_n,
  input wire logic [sync_rx_pkg::DATA_W-1:0] receive_data_reg,
  input wire logic rx_ninth_bit,
  input wire logic reception_error,
  input wire logic receive_complete_flag,
  input wire logic receive_irq
);
  // ------------
  // phase length
  // ------------
  logic prev_sck_reg;
  logic [DIV_W:0] run_len_reg;
  logic [DIV_W:0] half_len;
  assign half_len = (wide_divisor_select ? {1'b0, baud_divisor_pair} : {9'h000, baud_divisor_pair[7:0]}) + 17'h0_0001;
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_sck_reg <= 1'b0;
      run_len_reg <= 17'h0_0000;
    end else begin
      prev_sck_reg <= shift_clk_out;
      run_len_reg <= (shift_clk_out != prev_sck_reg) ? 17'h0_0001 : run_len_reg + 17'h0_0001;
    end
  end

  sequence s_off;
    (!single_receive_enable && !continuous_receive_enable) [*4];
  endsequence
  sequence s_held;
    receive_complete_flag && !data_read;
  endsequence

  // only the high phase is exact: low phase stretches between words and on stalls
  property p_high;
    @(posedge link_clk) disable iff (!rst_n)
    $fell(shift_clk_out) && (single_receive_enable || continuous_receive_enable) |-> run_len_reg == half_len;
  endproperty
  a_high: assert property (p_high) else $error("shift clock high phase length wrong");
  property p_low;
    @(posedge link_clk) disable iff (!rst_n) $rose(shift_clk_out) |-> run_len_reg >= half_len;
  endproperty
  a_low: assert property (p_low) else $error("shift clock low phase too short");
  property p_oe;
    @(posedge link_clk) disable iff (!rst_n) shift_clk_out |-> !shift_clk_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("shift clock high while not driven");
  property p_idle;
    @(posedge link_clk) disable iff (!rst_n) s_off |=> !$rose(shift_clk_out);
  endproperty
  a_idle: assert property (p_idle) else $error("shift clock started without enable");
  property p_irq_on;
    @(posedge ref_clk) disable iff (!rst_n) receive_complete_flag && $past(receive_interrupt_enable) |-> receive_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");
  property p_irq_off;
    @(posedge ref_clk) disable iff (!rst_n) !(receive_complete_flag && $past(receive_interrupt_enable)) |-> !receive_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");
  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    s_held |=> receive_complete_flag && $stable(receive_data_reg) && $stable(rx_ninth_bit);
  endproperty
  a_hold: assert property (p_hold) else $error("presented word changed before read");
  property p_err_clear;
    @(posedge ref_clk) disable iff (!rst_n) $fell(continuous_receive_enable) |-> ##[1:3] !reception_error;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error not cleared");
endmodule // sync_rx_monitor

bind sync_master_serial_receiver sync_rx_monitor mon (.ref_clk, .rst_n, .link_clk, .single_receive_enable,
  .continuous_receive_enable, .wide_divisor_select, .baud_divisor_pair, .receive_interrupt_enable, .data_read,
  .shift_clk_out, .shift_clk_oe_n, .receive_data_reg, .rx_ninth_bit, .reception_error, .receive_complete_flag,
  .receive_irq);
`default_nettype wire

//--- testbench/sync_slave_model.sv
// serial slave that shifts queued words out on the device's shift clock
`timescale 1ns/100ps
`default_nettype none

module sync_slave_model (
  input wire logic shift_clk,
  input wire logic nine,
  output logic data
);
  logic [8:0] words[$];
  int idx = 0;
  initial data = 1'b1;
  // new bit on the rise so it is settled at the sampling fall
  always @(posedge shift_clk) data <= (words.size() > 0) ? words[0][idx] : ~data;
  always @(negedge shift_clk) begin
    if (words.size() > 0) begin
      idx = idx + 1;
      if (idx == (nine ? 9 : 8)) begin
        idx = 0;
        void'(words.pop_front());
        data <= ~data; // released line shows no stale level
      end
    end
  end
endmodule // sync_slave_model
`default_nettype wire

//--- testbench/tb_sync_master_serial_receiver.sv
// self-checking bench for the synchronous master receive path
`timescale 1ns/100ps
`default_nettype none

module tb_sync_master_serial_receiver;
  import sync_rx_pkg::*;
  logic ref_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, hold_rd = 1'b0;
  logic serial_port_enable = 1'b0, sync_mode_select = 1'b0, clock_source_master_select = 1'b0;
  logic single_receive_enable = 1'b0, continuous_receive_enable = 1'b0, ninth_bit_receive_enable = 1'b0;
  logic wide_divisor_select = 1'b0, receive_interrupt_enable = 1'b0, data_read = 1'b0;
  logic [DIV_W-1:0] baud_divisor_pair = 16'h0000;
  logic serial_data_input, shift_clk_out, shift_clk_oe_n, rx_ninth_bit, reception_error;
  logic receive_complete_flag, receive_irq;
  logic [DATA_W-1:0] receive_data_reg;
  logic [WORD_W-1:0] exp_q[$];
  int num_errors = 0, n_checks = 0, seed = 2;

  always #5 ref_clk = ~ref_clk;
  initial begin
    #33;
    forever #80 link_clk = ~link_clk;
  end

  sync_master_serial_receiver DUT (.ref_clk, .rst_n, .link_clk, .serial_port_enable, .sync_mode_select,
    .clock_source_master_select, .single_receive_enable, .continuous_receive_enable, .ninth_bit_receive_enable,
    .wide_divisor_select, .baud_divisor_pair, .receive_interrupt_enable, .data_read, .serial_data_input,
    .shift_clk_out, .shift_clk_oe_n, .receive_data_reg, .rx_ninth_bit, .reception_error, .receive_complete_flag,
    .receive_irq);
  sync_slave_model slave (.shift_clk(shift_clk_out), .nine(ninth_bit_receive_enable), .data(serial_data_input));

  // ------------
  // helpers
  // ------------
  task automatic fail(input string msg);
    num_errors++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask
  task automatic chk_bit(input logic got, input logic want);
    n_checks++;
    if (got !== want) fail("status level");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic send(input logic [WORD_W-1:0] w);
    slave.words.push_back(w);
    exp_q.push_back(ninth_bit_receive_enable ? w : {1'b0, w[7:0]});
  endtask
  task automatic quiet(input int n);
    int moves;
    logic last;
    moves = 0;
    last = shift_clk_out;
    repeat (n) begin
      @(posedge ref_clk);
      if (shift_clk_out !== last) moves++;
      last = shift_clk_out;
    end
    n_checks++;
    if (moves != 0) fail("shift clock active");
  endtask
  task automatic wait_empty(input int n);
    int i;
    for (i = 0; i < n && exp_q.size() > 0; i++) @(posedge ref_clk);
    if (exp_q.size() > 0) fail("word missing");
  endtask
  // drop enables inside a word so it aborts, then clear with the port off
  task automatic stop_and_clear();
    int i;
    wait_empty(9000);
    for (i = 0; i < 3000 && shift_clk_out !== 1'b1; i++) @(posedge ref_clk);
    single_receive_enable <= 1'b0;
    continuous_receive_enable <= 1'b0;
    cyc(200);
    chk_bit(reception_error, 1'b1);
    serial_port_enable <= 1'b0;
    continuous_receive_enable <= 1'b1;
    cyc(2);
    continuous_receive_enable <= 1'b0;
    cyc(4);
    chk_bit(reception_error, 1'b0);
    serial_port_enable <= 1'b1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // software side: read each presented word unless reads are held off
  always @(posedge ref_clk) begin
    if (receive_complete_flag === 1'b1 && data_read === 1'b0 && !hold_rd) begin
      n_checks++;
      if (exp_q.size() == 0 || {rx_ninth_bit, receive_data_reg} !== exp_q[0]) fail("word");
      if (exp_q.size() > 0) void'(exp_q.pop_front());
      data_read <= 1'b1;
    end else begin
      data_read <= 1'b0;
    end
  end

  initial begin
    cyc(40000);
    fail("timeout");
    report_and_stop();
  end

  initial begin
    cyc(10);
    rst_n <= 1'b1;
    cyc(1);
    serial_port_enable <= 1'b1;
    sync_mode_select <= 1'b1;
    clock_source_master_select <= 1'b1;
    baud_divisor_pair <= 16'h0102;
    receive_interrupt_enable <= 1'b1;
    quiet(300);
    $display("test idle done");
    send(9'($random(seed)));
    single_receive_enable <= 1'b1;
    wait_empty(3000);
    quiet(500);
    $display("test single done");
    single_receive_enable <= 1'b0;
    wide_divisor_select <= 1'b1;
    baud_divisor_pair <= 16'h0003;
    ninth_bit_receive_enable <= 1'b1;
    hold_rd <= 1'b1;
    cyc(1);
    repeat (6) send(9'($random(seed)));
    continuous_receive_enable <= 1'b1;
    cyc(7000);
    quiet(300);
    hold_rd <= 1'b0;
    stop_and_clear();
    $display("test continuous done");
    wide_divisor_select <= 1'b0;
    baud_divisor_pair <= 16'h0102;
    ninth_bit_receive_enable <= 1'b0;
    receive_interrupt_enable <= 1'b0;
    cyc(1);
    repeat (2) send(9'($random(seed)));
    single_receive_enable <= 1'b1;
    continuous_receive_enable <= 1'b1;
    stop_and_clear();
    $display("test both enables done");
    report_and_stop();
  end
endmodule // tb_sync_master_serial_receiver
`default_nettype wire
